// *** hw/timer_a_pkg.sv ***
// Behaviour
// - counter, period, compares, buffers 16 bits, flagged
// - compare count with zero, top, compares
// - hit effects appear on next timer tick
// - tick from prescaled clock or events
// - zero point when count becomes zero
// - maximum when every count bit is one
// - peak when count equals sequence top
// - update point copies valid buffers unless locked
// - enable starts counting at selected rate
// - event enable counts events, not clock ticks
// - counting up wraps to zero after peak
// - counting down reloads sequence top at zero
// - software count write wins, takes effect immediately
// - normal counting follows direction bit, prescaled ticks
// - direction write accepted anytime, used at once
// - events steer direction and restart counting
// - split mode gives two 8-bit counters
// - buffer write sets valid, update clears it
package timer_a_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int HALF_W = 8;
    localparam int CH_N = 3;
    localparam int PRESC_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_E = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_EV_CTRL = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_BUF = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_CMP0 = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_CMPBUF0 = 4'hB;
    localparam int CA_ENABLE = 0;
    localparam int CA_CLOCK_SELECT = 1;
    localparam int CA_SPLIT = 4;
    localparam int CB_WAVE = 0;
    localparam int CE_DIR = 0;
    localparam int CE_LOCK = 1;
    localparam int EV_COUNT = 0;
    localparam int EV_DIR = 1;
    localparam int EV_RESTART = 2;
    localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;
    localparam logic [DATA_W-1:0] ONE16 = 16'h0001;
    localparam logic [DATA_W-1:0] MAX16 = 16'hFFFF;
    localparam logic [DATA_W-1:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [HALF_W-1:0] ZERO8 = 8'h00;
    localparam logic [HALF_W-1:0] MAX8 = 8'hFF;
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 10'h000;
    localparam logic [PRESC_W-1:0] PRESC_ONE = 10'h001;
    typedef enum logic [1:0] {
        WAVE_NORMAL = 2'h0,
        WAVE_FREQ = 2'h1,
        WAVE_SINGLE = 2'h2,
        WAVE_DUAL = 2'h3
    } wave_mode_t;
    typedef struct packed {
        logic enable;
        logic [2:0] clock_select;
        logic split;
        wave_mode_t wave_mode;
        logic dir;
        logic lock_update;
        logic count_event_input_enable;
        logic dir_event_enable;
        logic restart_event_enable;
    } ctrl_t;
    typedef struct packed {
        logic [2*CH_N-1:0] match;
        logic [1:0] peak;
        logic [1:0] maximum;
        logic [1:0] zero;
    } tick_events_t;
    // ratio per clock select: 1,2,4,8,16,64,256,1024
    function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
        unique case (sel)
            3'h0: div_mask = 10'h000;
            3'h1: div_mask = 10'h001;
            3'h2: div_mask = 10'h003;
            3'h3: div_mask = 10'h007;
            3'h4: div_mask = 10'h00F;
            3'h5: div_mask = 10'h03F;
            3'h6: div_mask = 10'h0FF;
            3'h7: div_mask = 10'h3FF;
        endcase
    endfunction
endpackage

// *** hw/timer_a_base_counter.sv ***
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module timer_a_base_counter
    import timer_a_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic [DATA_W-1:0] write_data_i,
    input wire logic write_strobe_i,
    input wire logic read_strobe_i,
    output logic [DATA_W-1:0] read_data_o,
    input wire logic count_event_i,
    input wire logic direction_event_i,
    input wire logic restart_event_i,
    output tick_events_t tick_events_o,
    output logic [2*CH_N-1:0] waveform_out_o
);
    ctrl_t ctrl;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] period;
    logic [DATA_W-1:0] period_buffer;
    logic period_valid;
    logic [CH_N-1:0][DATA_W-1:0] compare_value;
    logic [CH_N-1:0][DATA_W-1:0] compare_buffer;
    logic [CH_N-1:0] compare_valid;
    logic [PRESC_W-1:0] presc;

    function automatic logic [DATA_W-1:0] step(
        input logic [DATA_W-1:0] v,
        input logic [DATA_W-1:0] top,
        input logic up
    );
        if (up) begin
            step = (v == top) ? ZERO16 : v + ONE16;
        end else begin
            step = (v == ZERO16) ? top : v - ONE16;
        end
    endfunction

    function automatic logic wave_fn(
        input wave_mode_t mode,
        input logic cur,
        input logic m,
        input logic z
    );
        unique case (mode)
            WAVE_NORMAL: wave_fn = 1'h0;
            WAVE_FREQ: wave_fn = m ? ~cur : cur;
            WAVE_SINGLE: wave_fn = m ? 1'h0 : (z ? 1'h1 : cur);
            WAVE_DUAL: wave_fn = m ? ~cur : cur;
        endcase
    endfunction

    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_ctrl_e;
    logic wr_ev_ctrl;
    logic wr_count;
    logic wr_period;
    logic wr_period_buf;
    logic [CH_N-1:0] wr_cmp;
    logic [CH_N-1:0] wr_cmp_buf;
    assign wr_ctrl_a = write_strobe_i && (address_i == ADDR_CTRL_A);
    assign wr_ctrl_b = write_strobe_i && (address_i == ADDR_CTRL_B);
    assign wr_ctrl_e = write_strobe_i && (address_i == ADDR_CTRL_E);
    assign wr_ev_ctrl = write_strobe_i && (address_i == ADDR_EV_CTRL);
    assign wr_count = write_strobe_i && (address_i == ADDR_COUNT);
    assign wr_period = write_strobe_i && (address_i == ADDR_PERIOD);
    assign wr_period_buf = write_strobe_i && (address_i == ADDR_PERIOD_BUF);

    // new direction applies from the next tick on
    logic down;
    logic up;
    assign down = ctrl.dir_event_enable ? direction_event_i : ctrl.dir;
    assign up = ~down;

    logic [PRESC_W-1:0] mask;
    logic prescale_hit;
    logic tick;
    logic restart;
    assign mask = div_mask(ctrl.clock_select);
    assign prescale_hit = (presc & mask) == mask;
    // event counting bypasses the prescaler entirely
    assign tick = ctrl.enable && (ctrl.count_event_input_enable ?
        count_event_i : prescale_hit);
    assign restart = ctrl.enable && ctrl.restart_event_enable && restart_event_i;

    logic [DATA_W-1:0] top16;
    assign top16 = (ctrl.wave_mode == WAVE_FREQ) ? compare_value[0] : period;

    logic [1:0] zero_hit;
    logic [1:0] peak_hit;
    logic [1:0] max_hit;
    logic [2*CH_N-1:0] match_hit;
    assign zero_hit[0] = ctrl.split ? (count[HALF_W-1:0] == ZERO8) :
        (count == ZERO16);
    assign zero_hit[1] = ctrl.split && (count[DATA_W-1:HALF_W] == ZERO8);
    assign peak_hit[0] = ctrl.split ? (count[HALF_W-1:0] == period[HALF_W-1:0]) :
        (count == top16);
    assign peak_hit[1] = ctrl.split &&
        (count[DATA_W-1:HALF_W] == period[DATA_W-1:HALF_W]);
    assign max_hit[0] = ctrl.split ? (count[HALF_W-1:0] == MAX8) :
        (count == MAX16);
    assign max_hit[1] = ctrl.split && (count[DATA_W-1:HALF_W] == MAX8);

    logic [2*CH_N-1:0] wave_q;
    logic [2*CH_N-1:0] next_wave;

    genvar gi;
    generate
        for (gi = 0; gi < CH_N; gi++) begin : g_chan
            assign wr_cmp[gi] = write_strobe_i &&
                (address_i == ADDR_CMP0 + ADDR_W'(gi));
            assign wr_cmp_buf[gi] = write_strobe_i &&
                (address_i == ADDR_CMPBUF0 + ADDR_W'(gi));
            assign match_hit[gi] = ctrl.split ?
                (count[HALF_W-1:0] == compare_value[gi][HALF_W-1:0]) :
                (count == compare_value[gi]);
            assign match_hit[gi+CH_N] = ctrl.split &&
                (count[DATA_W-1:HALF_W] == compare_value[gi][DATA_W-1:HALF_W]);
        end
        for (gi = 0; gi < 2*CH_N; gi++) begin : g_wave
            localparam int H = gi / CH_N;
            logic active;
            assign active = (gi < CH_N) || ctrl.split;
            assign next_wave[gi] = !active ? 1'h0 :
                tick ? wave_fn(ctrl.wave_mode, wave_q[gi], match_hit[gi],
                zero_hit[H]) : wave_q[gi];
        end
    endgenerate

    tick_events_t hits;
    assign hits = '{match: match_hit, peak: peak_hit, maximum: max_hit, zero: zero_hit};

    // the counter steps from the value reached at the previous tick
    logic [DATA_W-1:0] step_full;
    logic [DATA_W-1:0] step_lo;
    logic [DATA_W-1:0] step_hi;
    logic [DATA_W-1:0] next_tick_count;
    logic [DATA_W-1:0] next_count;
    assign step_full = step(count, top16, up);
    assign step_lo = step({ZERO8, count[HALF_W-1:0]}, {ZERO8, period[HALF_W-1:0]}, up);
    assign step_hi = step({ZERO8, count[DATA_W-1:HALF_W]},
        {ZERO8, period[DATA_W-1:HALF_W]}, up);
    assign next_tick_count = ctrl.split ?
        {step_hi[HALF_W-1:0], step_lo[HALF_W-1:0]} : step_full;
    // software write beats restart, which beats counting
    assign next_count = wr_count ? write_data_i :
        restart ? ZERO16 :
        tick ? next_tick_count : count;

    // split halves share the low half's update point
    logic at_peak_mode;
    logic update;
    assign at_peak_mode = (ctrl.wave_mode == WAVE_NORMAL) || (ctrl.wave_mode == WAVE_FREQ);
    assign update = tick && !ctrl.lock_update &&
        (at_peak_mode ? peak_hit[0] : zero_hit[0]);

    logic [DATA_W-1:0] next_period;
    logic next_period_valid;
    assign next_period = wr_period ? write_data_i :
        (update && period_valid) ? period_buffer : period;
    // a buffer write in the update cycle keeps its flag set
    assign next_period_valid = wr_period_buf ? 1'h1 :
        update ? 1'h0 : period_valid;

    logic [DATA_W-1:0] status_word;
    assign status_word = {{(DATA_W-2-CH_N-1){1'h0}}, ctrl.enable, down,
        compare_valid, period_valid};

    logic [DATA_W-1:0] read_word;
    always_comb begin
        read_word = ZERO16;
        unique case (address_i)
            ADDR_CTRL_A: begin
                read_word[CA_ENABLE] = ctrl.enable;
                read_word[CA_CLOCK_SELECT +: 3] = ctrl.clock_select;
                read_word[CA_SPLIT] = ctrl.split;
            end
            ADDR_CTRL_B: read_word[CB_WAVE +: 2] = ctrl.wave_mode;
            ADDR_CTRL_E: begin
                read_word[CE_DIR] = ctrl.dir;
                read_word[CE_LOCK] = ctrl.lock_update;
            end
            ADDR_EV_CTRL: begin
                read_word[EV_COUNT] = ctrl.count_event_input_enable;
                read_word[EV_DIR] = ctrl.dir_event_enable;
                read_word[EV_RESTART] = ctrl.restart_event_enable;
            end
            ADDR_STATUS: read_word = status_word;
            ADDR_COUNT: read_word = count;
            ADDR_PERIOD: read_word = period;
            ADDR_PERIOD_BUF: read_word = period_buffer;
            ADDR_CMP0: read_word = compare_value[0];
            ADDR_CMP0 + 4'h1: read_word = compare_value[1];
            ADDR_CMP0 + 4'h2: read_word = compare_value[2];
            ADDR_CMPBUF0: read_word = compare_buffer[0];
            ADDR_CMPBUF0 + 4'h1: read_word = compare_buffer[1];
            ADDR_CMPBUF0 + 4'h2: read_word = compare_buffer[2];
            default: read_word = ZERO16;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl <= '0;
        end else begin
            if (wr_ctrl_a) begin
                ctrl.enable <= write_data_i[CA_ENABLE];
                ctrl.clock_select <= write_data_i[CA_CLOCK_SELECT +: 3];
                ctrl.split <= write_data_i[CA_SPLIT];
            end
            if (wr_ctrl_b) begin
                ctrl.wave_mode <= wave_mode_t'(write_data_i[CB_WAVE +: 2]);
            end
            if (wr_ctrl_e) begin
                ctrl.dir <= write_data_i[CE_DIR];
                ctrl.lock_update <= write_data_i[CE_LOCK];
            end
            if (wr_ev_ctrl) begin
                ctrl.count_event_input_enable <= write_data_i[EV_COUNT];
                ctrl.dir_event_enable <= write_data_i[EV_DIR];
                ctrl.restart_event_enable <= write_data_i[EV_RESTART];
            end
        end
    end

    // prescaler restarts from zero so the first tick has a full ratio
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            presc <= PRESC_ZERO;
        end else if (!ctrl.enable || restart) begin
            presc <= PRESC_ZERO;
        end else begin
            presc <= presc + PRESC_ONE;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= ZERO16;
            period <= PERIOD_RESET;
            period_buffer <= PERIOD_RESET;
            period_valid <= 1'h0;
        end else begin
            count <= next_count;
            period <= next_period;
            period_valid <= next_period_valid;
            if (wr_period_buf) begin
                period_buffer <= write_data_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            compare_value <= '0;
            compare_buffer <= '0;
            compare_valid <= '0;
        end else begin
            for (int i = 0; i < CH_N; i++) begin
                if (wr_cmp[i]) begin
                    compare_value[i] <= write_data_i;
                end else if (update && compare_valid[i]) begin
                    compare_value[i] <= compare_buffer[i];
                end
                if (wr_cmp_buf[i]) begin
                    compare_buffer[i] <= write_data_i;
                    compare_valid[i] <= 1'h1;
                end else if (update) begin
                    compare_valid[i] <= 1'h0;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wave_q <= '0;
            tick_events_o <= '0;
            read_data_o <= ZERO16;
        end else begin
            wave_q <= next_wave;
            tick_events_o <= tick ? hits : '0;
            read_data_o <= read_strobe_i ? read_word : ZERO16;
        end
    end

    assign waveform_out_o = wave_q;
endmodule

// *** testbench/event_source.sv ***
`timescale 1ns/1ps
module event_source (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic go_i,
    input wire logic [7:0] burst_i,
    input wire logic dir_i,
    input wire logic restart_i,
    output logic count_event_o,
    output logic direction_event_o,
    output logic restart_event_o,
    output logic busy_o
);
    logic [8:0] left;
    // direction event is a level, high asks for down counting
    assign direction_event_o = dir_i;
    assign busy_o = (left != 9'h000) || count_event_o;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            left <= 9'h000;
            count_event_o <= 1'b0;
            restart_event_o <= 1'b0;
        end else begin
            restart_event_o <= restart_i;
            // idle cycle between pulses so each is one separate tick
            count_event_o <= left[0];
            if (go_i) begin
                left <= {burst_i, 1'b0};
            end else if (left != 9'h000) begin
                left <= left - 9'h001;
            end
        end
    end
endmodule

// *** testbench/timer_a_checker.sv ***
`timescale 1ns/1ps
module timer_a_checker
    import timer_a_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic [DATA_W-1:0] write_data_i,
    input wire logic write_strobe_i,
    input wire logic read_strobe_i,
    input wire logic [DATA_W-1:0] read_data_o,
    input wire logic count_event_i,
    input wire logic direction_event_i,
    input wire logic restart_event_i,
    input wire tick_events_t tick_events_o,
    input wire logic [2*CH_N-1:0] waveform_out_o
);
    logic en_q;
    logic sp_q;
    wire ctrl_wr = write_strobe_i && (address_i == ADDR_CTRL_A);
    // shadow of enable and split, seen only through the bus
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_q <= 1'b0;
            sp_q <= 1'b0;
        end else if (ctrl_wr) begin
            en_q <= write_data_i[CA_ENABLE];
            sp_q <= write_data_i[CA_SPLIT];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    property p_read_idle;
        !$past(read_strobe_i) |-> read_data_o == ZERO16;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not idle");
    property p_unmapped;
        read_strobe_i && address_i > 4'hD |=> read_data_o == ZERO16;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
    property p_count_wr;
        write_strobe_i && address_i == ADDR_COUNT ##1 read_strobe_i && address_i == ADDR_COUNT
            |=> read_data_o == $past(write_data_i, 2);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count write lost");
    property p_dir_rw;
        write_strobe_i && address_i == ADDR_CTRL_E ##1 read_strobe_i && address_i == ADDR_CTRL_E
            |=> read_data_o == {14'h0000, $past(write_data_i[1:0], 2)};
    endproperty
    a_dir_rw: assert property (p_dir_rw) else $error("direction write lost");
    property p_ctrl_a_rw;
        write_strobe_i && address_i == ADDR_CTRL_A ##1 read_strobe_i && address_i == ADDR_CTRL_A
            |=> read_data_o == {11'h000, $past(write_data_i[4:0], 2)};
    endproperty
    a_ctrl_a_rw: assert property (p_ctrl_a_rw) else $error("control write lost");
    property p_bv_set;
        write_strobe_i && address_i == ADDR_PERIOD_BUF ##1 read_strobe_i && address_i == ADDR_STATUS
            |=> read_data_o[0];
    endproperty
    a_bv_set: assert property (p_bv_set) else $error("valid flag not set");
    property p_quiet;
        !en_q && !$past(en_q) |-> tick_events_o == 12'h000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("event while disabled");
    property p_no_split;
        !sp_q && !$past(sp_q) |-> {tick_events_o.match[5:3], tick_events_o.peak[1],
            tick_events_o.maximum[1], tick_events_o.zero[1], waveform_out_o[5:3]} == 9'h000;
    endproperty
    a_no_split: assert property (p_no_split) else $error("high half active unsplit");
endmodule
bind timer_a_base_counter timer_a_checker chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .address_i(address_i), .write_data_i(write_data_i), .write_strobe_i(write_strobe_i),
    .read_strobe_i(read_strobe_i), .read_data_o(read_data_o), .count_event_i(count_event_i),
    .direction_event_i(direction_event_i), .restart_event_i(restart_event_i),
    .tick_events_o(tick_events_o), .waveform_out_o(waveform_out_o));

// *** testbench/test_timer_a_base_counter.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_timer_a_base_counter
    import timer_a_pkg::*;
;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [ADDR_W-1:0] address_i = 4'h0;
    logic [DATA_W-1:0] write_data_i = 16'h0000;
    logic write_strobe_i = 1'b0;
    logic read_strobe_i = 1'b0;
    logic [DATA_W-1:0] read_data_o;
    logic count_event_i, direction_event_i, restart_event_i, busy;
    tick_events_t tick_events_o;
    logic [2*CH_N-1:0] waveform_out_o;
    logic go = 1'b0;
    logic [7:0] burst = 8'h00;
    logic dir = 1'b0;
    logic rst_req = 1'b0;
    int n_errors = 0, compares = 0, cyc = 0;
    int nz = 0, np = 0, nm = 0, nx = 0, b0, b1;
    logic [DATA_W-1:0] v, ex;
    initial forever #10 clock_i = ~clock_i;
    timer_a_base_counter uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .address_i(address_i),
        .write_data_i(write_data_i), .write_strobe_i(write_strobe_i),
        .read_strobe_i(read_strobe_i), .read_data_o(read_data_o), .count_event_i(count_event_i),
        .direction_event_i(direction_event_i), .restart_event_i(restart_event_i),
        .tick_events_o(tick_events_o), .waveform_out_o(waveform_out_o));
    event_source evs (.clock_i(clock_i), .arst_n_i(arst_n_i), .go_i(go), .burst_i(burst),
        .dir_i(dir), .restart_i(rst_req), .count_event_o(count_event_i),
        .direction_event_o(direction_event_i), .restart_event_o(restart_event_i), .busy_o(busy));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ceiling well above the prescaler sweep, the longest test
    always @(posedge clock_i) begin
        cyc++;
        if (tick_events_o.zero[0] === 1'b1) nz++;
        if (tick_events_o.peak[0] === 1'b1) np++;
        if (tick_events_o.match[0] === 1'b1) nm++;
        if (tick_events_o.maximum[0] === 1'b1) nx++;
        if (cyc == 40000) begin
            n_errors++;
            print_verdict();
        end
    end
    // back-to-back writes keep the strobe high; the next other access drops it
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        address_i <= a;
        write_data_i <= d;
        write_strobe_i <= 1'b1;
        @(posedge clock_i);
    endtask
    // read data stand in the cycle after the strobe, taken at the next edge
    task automatic rd(input logic [ADDR_W-1:0] a);
        write_strobe_i <= 1'b0;
        address_i <= a;
        read_strobe_i <= 1'b1;
        @(posedge clock_i);
        read_strobe_i <= 1'b0;
        @(posedge clock_i);
        v = read_data_o;
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rd(a);
        `CHK(v, e)
    endtask
    task automatic pulses(input logic [7:0] n);
        int i;
        write_strobe_i <= 1'b0;
        go <= 1'b1;
        burst <= n;
        @(posedge clock_i);
        go <= 1'b0;
        #1;
        for (i = 0; i < 600 && busy === 1'b1; i++) @(posedge clock_i);
        repeat (2) @(posedge clock_i);
    endtask
    initial begin
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(posedge clock_i);
        rchk(ADDR_PERIOD, 16'hFFFF);
        rchk(ADDR_PERIOD_BUF, 16'hFFFF);
        rchk(ADDR_COUNT, 16'h0000);
        rchk(4'hE, 16'h0000);
        rchk(ADDR_STATUS, 16'h0000);
        $display("reset values done");
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_COUNT, 16'h0000);
            wr(ADDR_CTRL_A, {12'h000, s[2:0], 1'b1});
            write_strobe_i <= 1'b0;
            repeat (2047) @(posedge clock_i);
            wr(ADDR_CTRL_A, 16'h0000);
            ex = 16'h0800 >> (s < 4 ? s : 2 * s - 4);
            rd(ADDR_COUNT);
            `CHK((v == ex || v == ex - 16'h0001), 1'b1)
        end
        $display("prescaler done");
        wr(ADDR_EV_CTRL, 16'h0001);
        wr(ADDR_PERIOD, 16'h0003);
        wr(ADDR_COUNT, 16'h0002);
        rchk(ADDR_COUNT, 16'h0002);
        wr(ADDR_CTRL_A, 16'h0001);
        rchk(ADDR_CTRL_A, 16'h0001);
        b0 = np;
        b1 = nz;
        pulses(3);
        rchk(ADDR_COUNT, 16'h0001);
        `CHK(np - b0, 1)
        `CHK(nz - b1, 1)
        wr(ADDR_CTRL_E, 16'h0001);
        rchk(ADDR_CTRL_E, 16'h0001);
        wr(ADDR_COUNT, 16'h0001);
        b1 = nz;
        pulses(3);
        rchk(ADDR_COUNT, 16'h0002);
        `CHK(nz - b1, 1)
        $display("event counting done");
        wr(ADDR_CTRL_E, 16'h0000);
        wr(ADDR_EV_CTRL, 16'h0007);
        dir <= 1'b1;
        wr(ADDR_COUNT, 16'h0005);
        pulses(1);
        rchk(ADDR_COUNT, 16'h0004);
        rst_req <= 1'b1;
        @(posedge clock_i);
        rst_req <= 1'b0;
        repeat (3) @(posedge clock_i);
        rchk(ADDR_COUNT, 16'h0000);
        dir <= 1'b0;
        wr(ADDR_EV_CTRL, 16'h0001);
        $display("event control done");
        wr(ADDR_CTRL_E, 16'h0002);
        wr(ADDR_PERIOD_BUF, 16'h0005);
        rchk(ADDR_STATUS, 16'h0021);
        wr(ADDR_CMPBUF0, 16'h0001);
        wr(ADDR_COUNT, 16'h0003);
        pulses(1);
        rchk(ADDR_PERIOD, 16'h0003);
        wr(ADDR_CTRL_E, 16'h0000);
        wr(ADDR_COUNT, 16'h0003);
        pulses(1);
        rchk(ADDR_PERIOD, 16'h0005);
        rchk(ADDR_CMP0, 16'h0001);
        rchk(ADDR_STATUS, 16'h0020);
        b0 = nm;
        pulses(2);
        `CHK(nm - b0, 1)
        $display("buffering done");
        wr(ADDR_PERIOD, 16'hFFFF);
        wr(ADDR_COUNT, 16'hFFFF);
        b0 = nx;
        pulses(1);
        `CHK(nx - b0, 1)
        rchk(ADDR_COUNT, 16'h0000);
        wr(ADDR_PERIOD, 16'h0202);
        wr(ADDR_COUNT, 16'h0102);
        wr(ADDR_CTRL_A, 16'h0011);
        pulses(1);
        rchk(ADDR_COUNT, 16'h0200);
        $display("maximum and split done");
        wr(ADDR_CTRL_A, 16'h0001);
        wr(ADDR_CTRL_B, 16'h0001);
        wr(ADDR_CMP0, 16'h0001);
        wr(ADDR_COUNT, 16'h0000);
        pulses(2);
        `CHK(waveform_out_o, 6'h07)
        rchk(ADDR_COUNT, 16'h0000);
        wr(ADDR_CTRL_B, 16'h0002);
        pulses(1);
        `CHK(waveform_out_o, 6'h01)
        wr(ADDR_CTRL_B, 16'h0003);
        pulses(1);
        `CHK(waveform_out_o, 6'h00)
        rchk(ADDR_COUNT, 16'h0002);
        wr(ADDR_CTRL_A, 16'h0000);
        $display("waveform done");
        print_verdict();
    end
endmodule
